// ### core/elic_core.sv
// Level, pin and peripheral interrupt arbiter with external vector fetch.
//
// How it works
// (R1) Debug interrupt pends at level 15 and loads mask 15 when taken.
// (R2) Active-low pin code 0000 is level 15, counting down; 1111 idle.
// (R3) Auto vectors 71 down to 64, two adjacent levels per vector.
// (R4) External vector mode takes vector 0 to 127 from data pins.
// (R5) External supplier drives the top data line low.
// (R6) Encoded external fetch shows level on outputs, strobes, samples data.
// (R7) Accepting an encoded level loads its level into the core mask.
// (R8) Pin mode bit set makes the four pins independent requests.
// (R9) Each pin senses low level, rising, falling or both edges.
// (R10) Each independent pin has its own priority 0 to 15.
// (R11) Independent pin external fetch shows priority, strobes, samples data.
// (R12) Accepting an independent pin loads its priority into the mask.
// (R13) Chip selects stay high and upper address is don't-care in fetch.
// (R14) Fetch honours the wait input but adds no programmed waits.
// (R15) Every peripheral source has its own distinct vector.
// (R16) Peripheral priority comes from four priority registers; mask loaded.
// (R17) Acceptance fetches the handler address from the selected entry.
// (R18) Sources sharing one priority field keep a fixed ranking.
// (R19) Reset gives every peripheral source priority 0.
// (R20) Equal simultaneous priorities resolve by a fixed default order.
// (R21) Priority 0 means masked, never accepted.
// (R22) Entry address is vector base plus four times vector number.
// (R23) Accept only above current mask, highest pending priority first.
// (R24) External source holds its code steady until accepted.
`timescale 1ns/1ps
`include "elic_consts.svh"

module elic_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] encodedRequestPinsN,
  input wire logic debugSerialPortIrq,
  input wire logic [`ELIC_NUM_PERI-1:0] periphReq,
  input wire logic [7:0] vectorDataIn,
  input wire logic waitN,
  input wire logic [4:0] chipSelectReqN,
  input wire logic [24:4] addrUpperIn,
  output logic [4:0] chipSelectOutputsN,
  output logic [24:4] addrUpperOut,
  output elic_pkg::elic_level_t acceptedLevelOutputs,
  output logic vectorFetchStrobeN,
  output elic_pkg::elic_level_t coreMaskLevelBits,
  output logic acceptPulse,
  output elic_pkg::elic_vec_t acceptedVector,
  output logic [31:0] vectorEntryAddr
);
  import elic_pkg::*;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [3:0] pinMeta_q, pinSync_q, pinPrev_q;
  logic [7:0] dataMeta_q, dataSync_q;
  logic waitMeta_q, waitSync_q;

  always_ff @(posedge mclk)
  begin
    pinMeta_q <= encodedRequestPinsN;
    pinSync_q <= pinMeta_q;
    pinPrev_q <= pinSync_q;
    dataMeta_q <= vectorDataIn;
    dataSync_q <= dataMeta_q;
    waitMeta_q <= waitN;
    waitSync_q <= waitMeta_q;
  end

  // ****************************************************
  // Register file
  // ****************************************************
  logic [1:0] ctrl_q;
  logic [7:0] sense_q;
  logic [15:0] pinPri_q, priA_q, priB_q, priD_q, priE_q;
  logic [31:0] vbase_q;
  elic_level_t mask_q, mask_d;
  logic [31:0] prdata_q;
  elic_state_t state_q, state_d;

  wire vecSel = ctrl_q[`ELIC_BIT_VECSEL];
  wire pinMode = ctrl_q[`ELIC_BIT_PINMODE];
  wire setupPh = psel && !penable;
  wire accessPh = psel && penable;
  wire wrEn = accessPh && pwrite;
  wire hitCtrl = paddr == `ELIC_OFF_CTRL;
  wire hitSense = paddr == `ELIC_OFF_SENSE;
  wire hitPinPri = paddr == `ELIC_OFF_PINPRI;
  wire hitA = paddr == `ELIC_OFF_PRI_A;
  wire hitB = paddr == `ELIC_OFF_PRI_B;
  wire hitD = paddr == `ELIC_OFF_PRI_D;
  wire hitE = paddr == `ELIC_OFF_PRI_E;
  wire hitVbase = paddr == `ELIC_OFF_VBASE;
  wire hitMask = paddr == `ELIC_OFF_MASK;
  wire hitStat = paddr == `ELIC_OFF_STAT;
  wire mapped = hitCtrl | hitSense | hitPinPri | hitA | hitB | hitD | hitE
    | hitVbase | hitMask | hitStat;
  wire [31:0] statWord = {16'h0000, pinSync_q, mask_q, 6'h00, state_q};
  wire [31:0] readMux =
    hitCtrl ? {30'h0, ctrl_q} :
    hitSense ? {24'h0, sense_q} :
    hitPinPri ? {16'h0, pinPri_q} :
    hitA ? {16'h0, priA_q} :
    hitB ? {16'h0, priB_q} :
    hitD ? {16'h0, priD_q} :
    hitE ? {16'h0, priE_q} :
    hitVbase ? vbase_q :
    hitMask ? {28'h0, mask_q} :
    hitStat ? statWord : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = accessPh && !mapped;
  assign prdata = prdata_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_q <= 2'h0;
      sense_q <= 8'h00;
      pinPri_q <= `ELIC_RST_REG16;
      priA_q <= `ELIC_RST_REG16; // R19
      priB_q <= `ELIC_RST_REG16; // R19
      priD_q <= `ELIC_RST_REG16; // R19
      priE_q <= `ELIC_RST_REG16; // R19
      vbase_q <= `ELIC_RST_VBASE;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      if (setupPh)
        prdata_q <= readMux;
      if (wrEn && hitCtrl)
        ctrl_q <= pwdata[1:0];
      if (wrEn && hitSense)
        sense_q <= pwdata[7:0];
      if (wrEn && hitPinPri)
        pinPri_q <= pwdata[15:0];
      if (wrEn && hitA)
        priA_q <= pwdata[15:0];
      if (wrEn && hitB)
        priB_q <= pwdata[15:0];
      if (wrEn && hitD)
        priD_q <= pwdata[15:0];
      if (wrEn && hitE)
        priE_q <= pwdata[15:0];
      if (wrEn && hitVbase)
        vbase_q <= pwdata;
    end
  end

  // ****************************************************
  // Request detection
  // ****************************************************
  logic debugPend_q;
  logic [3:0] edgePend_q;
  logic [3:0] pinEdge, pinLow;
  logic takeNow;
  logic [4:0] bestIdx;

  function automatic logic edgeHit(input logic [1:0] mode, input logic prv,
    input logic cur);
    edgeHit = (mode == `ELIC_SENSE_RISE && !prv && cur) ||
      (mode == `ELIC_SENSE_FALL && prv && !cur) ||
      (mode == `ELIC_SENSE_BOTH && prv != cur);
  endfunction

  function automatic elic_vec_t autoVec(input elic_level_t lvl);
    autoVec = `ELIC_VEC_AUTO_BASE + {5'h00, lvl[3:1]}; // R3
  endfunction

  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      pinEdge[p] = edgeHit(sense_q[2*p+:2], pinPrev_q[p], pinSync_q[p]); // R9
      pinLow[p] = sense_q[2*p+:2] == `ELIC_SENSE_LOW && !pinSync_q[p]; // R9
    end
  end

  // A flag raised in the cycle it is consumed stays raised.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      debugPend_q <= 1'b0;
      edgePend_q <= 4'h0;
    end
    else
    begin
      debugPend_q <= debugSerialPortIrq ||
        (debugPend_q && !(takeNow && bestIdx == 5'd0)); // R1
      for (int p = 0; p < 4; p++)
        edgePend_q[p] <= pinMode && (pinEdge[p] ||
          (edgePend_q[p] && !(takeNow && bestIdx == 5'(p + 2)))); // R8
    end
  end

  // ****************************************************
  // Candidates and arbitration
  // ****************************************************
  logic candReq [`ELIC_NUM_CAND];
  elic_level_t candLvl [`ELIC_NUM_CAND];
  elic_vec_t candVec [`ELIC_NUM_CAND];
  logic candExt [`ELIC_NUM_CAND];
  logic bestValid;
  elic_level_t bestLvl;
  wire elic_level_t codeLvl = 4'hF - pinSync_q; // R2

  always_comb
  begin
    candReq[0] = debugPend_q;
    candLvl[0] = `ELIC_LVL_DEBUG; // R1
    candVec[0] = `ELIC_VEC_DEBUG;
    candExt[0] = 1'b0;
    candReq[1] = !pinMode && pinSync_q != `ELIC_CODE_IDLE; // R2
    candLvl[1] = codeLvl;
    candVec[1] = autoVec(codeLvl);
    candExt[1] = 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      candReq[p+2] = pinMode && (edgePend_q[p] || pinLow[p]); // R8
      candLvl[p+2] = pinPri_q[4*p+:4]; // R10
      candVec[p+2] = autoVec(pinPri_q[4*p+:4]);
      candExt[p+2] = 1'b1;
    end
    for (int s = 0; s < `ELIC_NUM_PERI; s++)
    begin
      // Two sources share each of the upper two fields of a register; the lower index always ranks first.
      candReq[s+6] = periphReq[s];
      case (s / 4)
        0: candLvl[s+6] = priA_q[15-4*(s/2%2)-:4]; // R16
        1: candLvl[s+6] = priB_q[15-4*(s/2%2)-:4]; // R16
        2: candLvl[s+6] = priD_q[15-4*(s/2%2)-:4]; // R16
        default: candLvl[s+6] = priE_q[15-4*(s/2%2)-:4]; // R16
      endcase
      candVec[s+6] = `ELIC_VEC_PERI_BASE + 8'(s); // R15
      candExt[s+6] = 1'b0;
    end
  end

  always_comb
  begin
    bestValid = 1'b0;
    bestIdx = 5'd0;
    bestLvl = mask_q; // R23
    for (int i = 0; i < `ELIC_NUM_CAND; i++)
    begin
      // Strictly greater keeps the earlier index on ties.
      if (candReq[i] && candLvl[i] != `ELIC_LVL_NONE && candLvl[i] > bestLvl)
      begin // R21 R20 R18 R23
        bestValid = 1'b1;
        bestIdx = 5'(i);
        bestLvl = candLvl[i];
      end
    end
  end

  // ****************************************************
  // Acceptance and vector fetch
  // ****************************************************
  elic_level_t fetchLvl_q;
  logic acceptPulse_q;
  elic_vec_t accVec_q;
  logic [31:0] entry_q;
  wire goExt = bestValid && vecSel && candExt[bestIdx];
  wire fetchDone = state_q == ELIC_FETCH && waitSync_q; // R14
  wire elic_vec_t extVec = {1'b0, dataSync_q[6:0]}; // R4 R5
  wire elic_vec_t finalVec = fetchDone ? extVec : candVec[bestIdx];
  wire elic_level_t finalLvl = fetchDone ? fetchLvl_q : bestLvl;
  wire doAccept = fetchDone || (state_q == ELIC_IDLE && bestValid && !goExt);

  assign takeNow = state_q == ELIC_IDLE && bestValid;

  always_comb
  begin
    state_d = state_q;
    mask_d = mask_q;
    case (state_q)
      ELIC_IDLE:
        if (goExt)
          state_d = ELIC_FETCH; // R6 R11
      ELIC_FETCH:
        if (waitSync_q)
          state_d = ELIC_IDLE; // R14
      default:
        state_d = ELIC_IDLE;
    endcase
    if (doAccept)
      mask_d = finalLvl; // R7 R12 R16 R1
    else if (wrEn && hitMask)
      mask_d = pwdata[3:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= ELIC_IDLE;
      mask_q <= 4'h0;
      fetchLvl_q <= 4'h0;
      acceptPulse_q <= 1'b0;
      accVec_q <= 8'h00;
      entry_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      mask_q <= mask_d;
      acceptPulse_q <= doAccept;
      if (takeNow)
      begin
        fetchLvl_q <= bestLvl;
      end
      if (doAccept)
      begin
        accVec_q <= finalVec;
        entry_q <= vbase_q + {22'h0, finalVec, 2'b00}; // R17 R22
      end
    end
  end

  wire fetching = state_q == ELIC_FETCH;
  assign acceptedLevelOutputs = fetching ? fetchLvl_q : 4'h0; // R6 R11
  assign vectorFetchStrobeN = !fetching; // R6 R11
  assign chipSelectOutputsN = fetching ? 5'h1F : chipSelectReqN; // R13
  assign addrUpperOut = fetching ? 21'h00000 : addrUpperIn; // R13
  assign coreMaskLevelBits = mask_q;
  assign acceptPulse = acceptPulse_q;
  assign acceptedVector = accVec_q;
  assign vectorEntryAddr = entry_q;

  // ****************************************************
  // Checks
  // ****************************************************
  a_mask_on_accept: assert property (@(posedge mclk) disable iff (rst) // R7
    doAccept |=> coreMaskLevelBits == $past(finalLvl))
    else $error("Mask not loaded with accepted level.");
  a_debug_level: assert property (@(posedge mclk) disable iff (rst) // R1
    (doAccept && !fetchDone && bestIdx == 5'd0) |=> coreMaskLevelBits == 4'hF)
    else $error("Debug interrupt did not load mask 15.");
  a_auto_vector: assert property (@(posedge mclk) disable iff (rst) // R3
    (doAccept && bestIdx == 5'd1 && !vecSel) |=>
    acceptedVector == 8'h40 + {5'h00, $past(bestLvl[3:1])})
    else $error("Auto vector wrong.");
  a_ext_vector: assert property (@(posedge mclk) disable iff (rst) // R4
    fetchDone |=> acceptedVector == {1'b0, $past(dataSync_q[6:0])})
    else $error("External vector not taken from data pins.");
  a_fetch_strobe: assert property (@(posedge mclk) disable iff (rst) // R6
    (takeNow && goExt) |=> !vectorFetchStrobeN &&
    acceptedLevelOutputs == $past(bestLvl))
    else $error("Fetch strobe or level output wrong.");
  a_cs_high: assert property (@(posedge mclk) disable iff (rst) // R13
    !vectorFetchStrobeN |-> chipSelectOutputsN == 5'h1F)
    else $error("Chip select active during fetch.");
  a_wait_stretch: assert property (@(posedge mclk) disable iff (rst) // R14
    (fetching && !waitSync_q) |=> fetching)
    else $error("Fetch ended while wait held.");
  a_no_extra_wait: assert property (@(posedge mclk) disable iff (rst) // R14
    (fetching && waitSync_q) |=> !fetching)
    else $error("Fetch stretched without wait.");
  a_above_mask: assert property (@(posedge mclk) disable iff (rst) // R23
    (doAccept && !fetchDone) |-> bestLvl > mask_q && bestLvl != 4'h0)
    else $error("Accepted at or below mask.");
  a_entry_addr: assert property (@(posedge mclk) disable iff (rst) // R22
    doAccept |=> vectorEntryAddr ==
    $past(vbase_q) + {22'h0, $past(finalVec), 2'b00})
    else $error("Entry address not base plus four times vector.");
  a_reset_prio: assert property (@(posedge mclk) // R19
    rst |=> priA_q == 16'h0000 && priB_q == 16'h0000 &&
    priD_q == 16'h0000 && priE_q == 16'h0000)
    else $error("Peripheral priority not zero after reset.");
endmodule // elic_core

// ### core/elic_consts.svh
// Offsets, field positions, reset values and fixed codes of the controller.
`ifndef ELIC_CONSTS_SVH
`define ELIC_CONSTS_SVH
`define ELIC_OFF_CTRL 8'h00
`define ELIC_OFF_SENSE 8'h04
`define ELIC_OFF_PINPRI 8'h08
`define ELIC_OFF_PRI_A 8'h0C
`define ELIC_OFF_PRI_B 8'h10
`define ELIC_OFF_PRI_D 8'h14
`define ELIC_OFF_PRI_E 8'h18
`define ELIC_OFF_VBASE 8'h1C
`define ELIC_OFF_MASK 8'h20
`define ELIC_OFF_STAT 8'h24
`define ELIC_BIT_VECSEL 0
`define ELIC_BIT_PINMODE 1
`define ELIC_RST_REG16 16'h0000
`define ELIC_RST_VBASE 32'h0000_0000
`define ELIC_LVL_DEBUG 4'hF
`define ELIC_LVL_NONE 4'h0
`define ELIC_VEC_DEBUG 8'h0D
`define ELIC_VEC_AUTO_BASE 8'h40
`define ELIC_VEC_PERI_BASE 8'h48
`define ELIC_CODE_IDLE 4'hF
`define ELIC_SENSE_LOW 2'h0
`define ELIC_SENSE_RISE 2'h1
`define ELIC_SENSE_FALL 2'h2
`define ELIC_SENSE_BOTH 2'h3
`define ELIC_NUM_PERI 16
`define ELIC_NUM_CAND 22
`endif

// ### core/elic_pkg.sv
// Types shared by the interrupt controller.
package elic_pkg;
  typedef enum logic [1:0] {
    ELIC_IDLE = 2'b00,
    ELIC_FETCH = 2'b01
  } elic_state_t;
  typedef logic [3:0] elic_level_t;
  typedef logic [7:0] elic_vec_t;
endpackage

// ### bench/elic_vec_model.sv
// Behavioural external vector supplier answering the fetch strobe.
`timescale 1ns/1ps
module elic_vec_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic vectorFetchStrobeN,
  input wire logic [6:0] vecNum,
  input wire logic [3:0] stall,
  output logic [7:0] vectorDataIn,
  output logic waitN
);
  logic [3:0] cnt_q;
  // ****************
  // Supplier
  // ****************
  // Wait is held low while idle: the controller sees it two cycles late
  // and would otherwise end a fetch before the vector is valid.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_q <= 4'h0;
      waitN <= 1'b1;
      vectorDataIn <= 8'hFF;
    end
    else if (!vectorFetchStrobeN)
    begin
      vectorDataIn <= {1'b0, vecNum};
      cnt_q <= cnt_q + 4'h1;
      waitN <= (cnt_q >= stall);
    end
    else
    begin
      vectorDataIn <= {1'b1, ~vecNum};
      cnt_q <= 4'h0;
      waitN <= 1'b0;
    end
  end
endmodule // elic_vec_model

// ### bench/tb_top.sv
// Self-checking bench for the interrupt controller.
`timescale 1ns/1ps
`include "elic_consts.svh"
module tb_top;
  import elic_pkg::*;
  localparam logic [31:0] VB = 32'h0000_1000;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, dbg = 0;
  logic [7:0] paddr = 8'h00, vecData, vec;
  logic [31:0] pwdata = 32'h0, prdata, rd, entry;
  logic pready, pslverr, er, waitN, strobeN, acc;
  logic [3:0] pinsN = 4'hF, lvlOut, mask, expLvl = 4'h0, stall = 4'h2;
  logic [15:0] periphReq = 16'h0;
  logic [6:0] vecNum = 7'h00;
  logic [4:0] csN;
  logic [24:4] addrOut;
  int n_mismatch = 0, comparisons = 0, cnt = 0;

  elic_core dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .encodedRequestPinsN(pinsN),
    .debugSerialPortIrq(dbg), .periphReq(periphReq),
    .vectorDataIn(vecData), .waitN(waitN), .chipSelectReqN(5'h00),
    .addrUpperIn(21'h0ABCD), .chipSelectOutputsN(csN),
    .addrUpperOut(addrOut), .acceptedLevelOutputs(lvlOut),
    .vectorFetchStrobeN(strobeN), .coreMaskLevelBits(mask),
    .acceptPulse(acc), .acceptedVector(vec), .vectorEntryAddr(entry));
  elic_vec_model partner (.mclk(mclk), .rst(rst),
    .vectorFetchStrobeN(strobeN), .vecNum(vecNum), .stall(stall),
    .vectorDataIn(vecData), .waitN(waitN));

  initial forever #2.5 mclk = ~mclk;

  // ****************
  // Tasks
  // ****************
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i == 50)
    begin
      n_mismatch++;
      end_of_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits for one acceptance and checks mask, vector and entry address.
  task wacc(input logic [3:0] l, input logic [7:0] v);
    int i;
    i = 0;
    @(negedge mclk);
    while (acc !== 1'b1 && i < 60)
    begin
      @(negedge mclk);
      i++;
    end
    if (i == 60)
    begin
      n_mismatch++;
      end_of_test;
    end
    chk(mask, l);
    chk(vec, v);
    chk(entry, VB + {22'h0, v, 2'b00});
  endtask
  task none;
    int seen;
    seen = 0;
    repeat (30)
    begin
      @(negedge mclk);
      if (acc === 1'b1)
        seen++;
    end
    chk(seen, 0);
  endtask
  task idle_pins;
    @(posedge mclk);
    pinsN <= 4'hF;
    apb(1'b1, `ELIC_OFF_MASK, 32'h0);
  endtask

  always @(negedge mclk)
  begin
    if (!rst && strobeN === 1'b0)
    begin
      cnt++;
      chk(lvlOut, expLvl);
      chk(csN, 5'h1F);
    end
    else if (!rst)
    begin
      chk(lvlOut, 4'h0);
      chk(csN, 5'h00);
      chk(addrOut, 21'h0ABCD);
    end
  end

  // ****************
  // Sequence
  // ****************
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 12; a <= 24; a += 4)
    begin
      apb(1'b0, a[7:0], 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h30, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, `ELIC_OFF_VBASE, VB);
    @(posedge mclk) dbg <= 1'b1;
    @(posedge mclk) dbg <= 1'b0;
    wacc(4'hF, `ELIC_VEC_DEBUG);
    apb(1'b1, `ELIC_OFF_MASK, 32'h0);
    for (int c = 0; c < 15; c++)
    begin
      @(posedge mclk) pinsN <= c[3:0];
      wacc(4'(15 - c), 8'h40 + 8'((15 - c) / 2));
      idle_pins;
    end
    apb(1'b1, `ELIC_OFF_MASK, 32'hA);
    @(posedge mclk) pinsN <= 4'hA;
    none;
    @(posedge mclk) pinsN <= 4'h2;
    wacc(4'hD, 8'h46);
    idle_pins;
    apb(1'b1, `ELIC_OFF_CTRL, 32'h1);
    for (int s = 2; s <= 6; s += 4)
    begin
      cnt = 0;
      expLvl = 4'h9;
      @(posedge mclk);
      stall <= s[3:0];
      vecNum <= 7'h55;
      pinsN <= 4'h6;
      wacc(4'h9, 8'h55);
      chk(cnt, s + 4);
      idle_pins;
    end
    apb(1'b1, `ELIC_OFF_CTRL, 32'h3);
    apb(1'b1, `ELIC_OFF_PINPRI, 32'h0600);
    expLvl = 4'h6;
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, `ELIC_OFF_SENSE, m << 4);
      @(posedge mclk);
      vecNum <= 7'h20 + 7'(m);
      pinsN <= 4'hB;
      if (m == 1)
      begin
        none;
        @(posedge mclk) pinsN <= 4'hF;
      end
      wacc(4'h6, 8'h20 + 8'(m));
      idle_pins;
      if (m == 3)
        wacc(4'h6, 8'h23);
      else
        none;
    end
    apb(1'b1, `ELIC_OFF_CTRL, 32'h2);
    apb(1'b1, `ELIC_OFF_MASK, 32'h0);
    @(posedge mclk) pinsN <= 4'hB;
    wacc(4'h6, 8'h43);
    idle_pins;
    wacc(4'h6, 8'h43);
    apb(1'b1, `ELIC_OFF_CTRL, 32'h0);
    apb(1'b1, `ELIC_OFF_MASK, 32'h0);
    @(posedge mclk) periphReq <= 16'h0003;
    none;
    apb(1'b1, `ELIC_OFF_PRI_A, 32'h5000);
    wacc(4'h5, 8'h48);
    @(posedge mclk) periphReq <= 16'h0002;
    apb(1'b1, `ELIC_OFF_MASK, 32'h0);
    wacc(4'h5, 8'h49);
    end_of_test;
  end
endmodule // tb_top
